// File: fmic_pkg.sv
package fmic_pkg;
  // clock and motor drive timing
  localparam int CLK_HZ = 10_000_000;
  localparam int PWM_NOM_HZ = 40_000;
  localparam int PWM_NOM_CYC = CLK_HZ / PWM_NOM_HZ;
  localparam logic [8:0] PWM_NOM_END = 9'(PWM_NOM_CYC - 1);
  localparam logic [8:0] PWM_HALF_END = 9'(2 * PWM_NOM_CYC - 1);
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int LPWM_STEPS = 32;

  // fixed range addresses (address bits 7:0, 256 maps to slot 0)
  localparam logic [7:0] ADR_START = 8'h02;
  localparam logic [7:0] ADR_IDX_UP = 8'h1F;
  localparam logic [7:0] ADR_IDX_LO = 8'h20;
  localparam logic [7:0] ADR_MOTOR_CFG = 8'h31;
  localparam logic [7:0] ADR_LOAD_INF = 8'h38;
  localparam int MOTOR_HALF_BIT = 1;

  // values after reset
  localparam logic [7:0] START_RST = 8'h03;
  localparam logic [7:0] IDX_UP_RST = 8'h10;
  localparam logic [7:0] IDX_LO_RST = 8'h00;
  localparam logic [7:0] MOTOR_CFG_RST = 8'h02;
  localparam logic [7:0] LOAD_INF_RST = 8'hFF;

  // banked range: upper index value and number of lower index banks held
  localparam logic [7:0] BANK_UP = 8'h10;
  localparam int NUM_BANKS = 4;
  localparam int LIGHT_BANK = 0;
  localparam int MAP_BANK = 2;

  // output configuration layout inside the light bank
  localparam int NUM_OUT = 6;
  localparam int MODE_OFS = 3;
  localparam int RATE_OFS = 4;
  localparam int BRIGHT_OFS = 6;
  localparam int SPEC_OFS = 7;
  localparam int OUT_STRIDE = 8;
  localparam int SPEC_PHASE = 0;
  localparam int SPEC_GC = 1;
  localparam int SPEC_DIM = 4;

  // mapping rows inside the map bank
  localparam int NUM_KEYS = 6;
  localparam int NUM_ROWS = 16;
  localparam int MAP_BASE = 10;
  localparam int ROW_STRIDE = 16;
  localparam int LOGIC_OFS = 2;
  localparam int LOGIC_DIM = 6;
  localparam int LOGIC_GC = 7;
  localparam int AUX_FOUR_BIT = 5;

  typedef enum logic [7:0] {
    MODE_OFF = 8'h00,
    MODE_DIM = 8'h01,
    MODE_FADE = 8'h02,
    MODE_FIRE = 8'h03,
    MODE_IFIRE = 8'h04,
    MODE_STROBE1 = 8'h05,
    MODE_STROBE2 = 8'h06,
    MODE_ROTARY = 8'h07,
    MODE_STRATO = 8'h08,
    MODE_DITCH1 = 8'h09,
    MODE_DITCH2 = 8'h0A,
    MODE_FLASH = 8'h0C,
    MODE_MARS = 8'h0D,
    MODE_GYRA = 8'h0E,
    MODE_COUPLER = 8'h1C
  } fmic_mode_t;
endpackage : fmic_pkg

// File: fmic_top.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module fmic_top #(
  parameter int TICK_CYCLES = fmic_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  // configuration access
  input wire logic [8:0] CFG_ADDR_IN,
  input wire logic [7:0] CFG_WDATA_IN,
  input wire logic CFG_WR_IN,
  input wire logic CFG_RD_IN,
  output logic [7:0] CFG_RDATA_OUT,
  // travel state from the command decoder
  input wire logic [5:0] FUNC_KEYS_IN,
  input wire logic DIR_REVERSE_IN,
  input wire logic MOVING_IN,
  input wire logic [7:0] SPEED_IN,
  input wire logic [7:0] EMF_IN,
  // motor drive
  output logic MOTOR_PWM_OUT,
  output logic LOAD_CTRL_ON_OUT,
  // physical outputs: head, rear, aux one to four
  output logic [5:0] LIGHT_OUT
);
  localparam int NO = fmic_pkg::NUM_OUT;

  logic [7:0] fixed_q [256];
  logic [7:0] bank_q [fmic_pkg::NUM_BANKS][256];
  logic [7:0] idx_up, idx_lo, load_inf, motor_cfg, start_v;
  logic bank_ok, addr_upper, pwm_half;

  // decode: 257..511 is the banked range, everything else of 1..256 is fixed
  assign addr_upper = CFG_ADDR_IN[8] && (CFG_ADDR_IN[7:0] != 8'h00);
  assign idx_up = fixed_q[fmic_pkg::ADR_IDX_UP];
  assign idx_lo = fixed_q[fmic_pkg::ADR_IDX_LO];
  assign bank_ok = (idx_up == fmic_pkg::BANK_UP) && (idx_lo < 8'(fmic_pkg::NUM_BANKS));
  assign load_inf = fixed_q[fmic_pkg::ADR_LOAD_INF];
  assign motor_cfg = fixed_q[fmic_pkg::ADR_MOTOR_CFG];
  assign start_v = fixed_q[fmic_pkg::ADR_START];
  assign pwm_half = !motor_cfg[fmic_pkg::MOTOR_HALF_BIT];

  // configuration storage; banks other than the held ones take no writes
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int i = 0; i < 256; i++) begin
        fixed_q[i] <= 8'h00;
        for (int b = 0; b < fmic_pkg::NUM_BANKS; b++) begin
          bank_q[b][i] <= 8'h00;
        end
      end
      fixed_q[fmic_pkg::ADR_START] <= fmic_pkg::START_RST;
      fixed_q[fmic_pkg::ADR_IDX_UP] <= fmic_pkg::IDX_UP_RST;
      fixed_q[fmic_pkg::ADR_IDX_LO] <= fmic_pkg::IDX_LO_RST;
      fixed_q[fmic_pkg::ADR_MOTOR_CFG] <= fmic_pkg::MOTOR_CFG_RST;
      fixed_q[fmic_pkg::ADR_LOAD_INF] <= fmic_pkg::LOAD_INF_RST;
    end else if (CFG_WR_IN && CFG_ADDR_IN != 9'h000) begin
      if (!addr_upper) begin
        fixed_q[CFG_ADDR_IN[7:0]] <= CFG_WDATA_IN;
      end else if (bank_ok) begin
        bank_q[idx_lo[1:0]][CFG_ADDR_IN[7:0]] <= CFG_WDATA_IN;
      end
    end
  end

  // read data stands one cycle after the strobe; unheld banks read zero
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      CFG_RDATA_OUT <= 8'h00;
    end else if (CFG_RD_IN && CFG_ADDR_IN != 9'h000 && !addr_upper) begin
      CFG_RDATA_OUT <= fixed_q[CFG_ADDR_IN[7:0]];
    end else if (CFG_RD_IN && addr_upper && bank_ok) begin
      CFG_RDATA_OUT <= bank_q[idx_lo[1:0]][CFG_ADDR_IN[7:0]];
    end else begin
      CFG_RDATA_OUT <= 8'h00;
    end
  end

  // mapping rows: 0/1 stand fwd/rev, 2/3 travel fwd/rev, then key k at 4+2k(+1 rev)
  logic [fmic_pkg::NUM_ROWS-1:0] row_act;
  logic [7:0] out_mask, logic_mask;
  always_comb begin
    row_act = '0;
    row_act[0] = !MOVING_IN && !DIR_REVERSE_IN;
    row_act[1] = !MOVING_IN && DIR_REVERSE_IN;
    row_act[2] = MOVING_IN && !DIR_REVERSE_IN;
    row_act[3] = MOVING_IN && DIR_REVERSE_IN;
    for (int k = 0; k < fmic_pkg::NUM_KEYS; k++) begin
      row_act[4 + 2 * k] = FUNC_KEYS_IN[k] && !DIR_REVERSE_IN;
      row_act[5 + 2 * k] = FUNC_KEYS_IN[k] && DIR_REVERSE_IN;
    end
    out_mask = 8'h00;
    logic_mask = 8'h00;
    for (int r = 0; r < fmic_pkg::NUM_ROWS; r++) begin
      if (row_act[r]) begin
        out_mask |= bank_q[fmic_pkg::MAP_BANK][fmic_pkg::MAP_BASE + r * fmic_pkg::ROW_STRIDE];
        logic_mask |= bank_q[fmic_pkg::MAP_BANK][fmic_pkg::MAP_BASE + fmic_pkg::LOGIC_OFS
                                                   + r * fmic_pkg::ROW_STRIDE];
      end
    end
  end

  // effect time base: a coarse tick keeps the per-output phase counters small
  logic [15:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
    end
  end

  // flicker source for the firebox effects
  logic [7:0] lfsr_q;
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lfsr_q <= 8'h01;
    end else if (tick) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  function automatic logic [4:0] fmic_effect(input logic [7:0] mode, input logic [7:0] ph,
                                            input logic [4:0] fade, input logic [7:0] rnd,
                                            input logic [7:0] speed, input logic flash);
    logic [4:0] tri_v;
    tri_v = ph[7] ? ~ph[6:2] : ph[6:2];
    unique case (mode)
      fmic_pkg::MODE_DIM, fmic_pkg::MODE_COUPLER: fmic_effect = 5'h1F;
      fmic_pkg::MODE_FADE: fmic_effect = fade;
      fmic_pkg::MODE_FIRE: fmic_effect = {1'b1, rnd[3:0]};
      fmic_pkg::MODE_IFIRE: fmic_effect = 5'h08 + 5'(speed[7:4]) + 5'(rnd[2:0]);
      fmic_pkg::MODE_STROBE1: fmic_effect = (ph < 8'h10) ? 5'h1F : 5'h00;
      fmic_pkg::MODE_STROBE2: begin
        fmic_effect = (ph < 8'h10 || (ph >= 8'h20 && ph < 8'h30)) ? 5'h1F : 5'h00;
      end
      fmic_pkg::MODE_ROTARY, fmic_pkg::MODE_MARS, fmic_pkg::MODE_GYRA: fmic_effect = tri_v;
      fmic_pkg::MODE_STRATO: fmic_effect = (ph[7:6] == 2'b00) ? 5'h1F : 5'h02;
      fmic_pkg::MODE_DITCH1: fmic_effect = (!flash || ph[7]) ? 5'h1F : 5'h00;
      fmic_pkg::MODE_DITCH2: fmic_effect = (flash && ph[7]) ? 5'h1F : 5'h00;
      fmic_pkg::MODE_FLASH: fmic_effect = ph[7] ? 5'h1F : 5'h00;
      default: fmic_effect = 5'h00;
    endcase
  endfunction : fmic_effect

  // brightness times effect; the dimmer halves the result
  function automatic logic [4:0] fmic_level(input logic [4:0] br, input logic [4:0] eff,
                                           input logic dim);
    logic [10:0] p;
    p = 11'(br) * (11'(eff) + 11'd1);
    fmic_level = dim ? {1'b0, p[9:6]} : p[9:5];
  endfunction : fmic_level

  // per-output configuration and drive level
  logic [7:0] mode_w [NO];
  logic [7:0] rate_w [NO];
  logic [7:0] spec_w [NO];
  logic [4:0] bright_w [NO];
  logic [4:0] level_w [NO];
  logic [7:0] phase_q [NO];
  logic [4:0] fade_q [NO];
  logic [NO-1:0] light_en, light_act;
  logic gc_flag, dim_flag;
  assign gc_flag = logic_mask[fmic_pkg::LOGIC_GC];
  assign dim_flag = logic_mask[fmic_pkg::LOGIC_DIM];
  always_comb begin
    for (int o = 0; o < NO; o++) begin
      mode_w[o] = bank_q[fmic_pkg::LIGHT_BANK][fmic_pkg::MODE_OFS + o * fmic_pkg::OUT_STRIDE];
      rate_w[o] = bank_q[fmic_pkg::LIGHT_BANK][fmic_pkg::RATE_OFS + o * fmic_pkg::OUT_STRIDE];
      spec_w[o] = bank_q[fmic_pkg::LIGHT_BANK][fmic_pkg::SPEC_OFS + o * fmic_pkg::OUT_STRIDE];
      bright_w[o] = bank_q[fmic_pkg::LIGHT_BANK][fmic_pkg::BRIGHT_OFS
                                               + o * fmic_pkg::OUT_STRIDE][4:0];
      light_en[o] = (mode_w[o] != fmic_pkg::MODE_OFF);
      light_act[o] = light_en[o] && out_mask[o]
                     && (!spec_w[o][fmic_pkg::SPEC_GC] || gc_flag);
      level_w[o] = fmic_level(bright_w[o],
                              fmic_effect(mode_w[o],
                                          phase_q[o] + (spec_w[o][fmic_pkg::SPEC_PHASE]
                                                        ? 8'h80 : 8'h00),
                                          fade_q[o], lfsr_q, SPEED_IN, gc_flag),
                              dim_flag && spec_w[o][fmic_pkg::SPEC_DIM]);
    end
  end

  // phase runs on each tick; gyra steps at half the beacon rate
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int o = 0; o < NO; o++) begin
        phase_q[o] <= 8'h00;
      end
    end else if (tick) begin
      for (int o = 0; o < NO; o++) begin
        if (mode_w[o] == fmic_pkg::MODE_GYRA) begin
          phase_q[o] <= phase_q[o] + 8'(rate_w[o][7:2]) + 8'h01;
        end else begin
          phase_q[o] <= phase_q[o] + 8'(rate_w[o][7:1]) + 8'h01;
        end
      end
    end
  end

  // fade ramps one level per tick both ways, so oil lamps glow up slowly
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      for (int o = 0; o < NO; o++) begin
        fade_q[o] <= 5'h00;
      end
    end else if (tick) begin
      for (int o = 0; o < NO; o++) begin
        if (light_act[o] && fade_q[o] != 5'h1F) begin
          fade_q[o] <= fade_q[o] + 5'h01;
        end else if (!light_act[o] && fade_q[o] != 5'h00) begin
          fade_q[o] <= fade_q[o] - 5'h01;
        end
      end
    end
  end

  // light pwm over 32 steps; a fading output may still glow while inactive
  logic [4:0] lpwm_cnt_q;
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lpwm_cnt_q <= 5'h00;
      LIGHT_OUT <= '0;
    end else begin
      lpwm_cnt_q <= lpwm_cnt_q + 5'h01;
      for (int o = 0; o < NO; o++) begin
        LIGHT_OUT[o] <= light_en[o] && (lpwm_cnt_q < level_w[o])
                        && (light_act[o] || mode_w[o] == fmic_pkg::MODE_FADE);
      end
    end
  end

  // load compensation: error times influence over 256, so 0 gives none at all
  logic signed [9:0] err_w, corr_w;
  logic signed [18:0] prod_w;
  logic signed [10:0] sum_w;
  logic [7:0] duty_w;
  assign err_w = $signed({2'b00, SPEED_IN}) - $signed({2'b00, EMF_IN});
  assign prod_w = err_w * $signed({1'b0, load_inf});
  assign corr_w = (load_inf == 8'h00) ? 10'sd0 : 10'(prod_w >>> 8);
  assign sum_w = $signed({3'b000, start_v}) + $signed({3'b000, SPEED_IN}) + 11'(corr_w);
  assign duty_w = (SPEED_IN == 8'h00 || sum_w < 0) ? 8'h00
                  : (sum_w > 11'sd255) ? 8'hFF : 8'(sum_w);

  function automatic logic [8:0] fmic_scale(input logic [7:0] d, input logic half);
    logic [17:0] p;
    p = 18'(d) * 18'(fmic_pkg::PWM_NOM_CYC);
    fmic_scale = half ? 9'(p >> 7) : 9'(p >> 8);
  endfunction : fmic_scale

  // duty is taken at the period start so a write never cuts a pulse short
  logic [8:0] mcnt_q, mcmp_q;
  logic mend;
  assign mend = (mcnt_q >= (pwm_half ? fmic_pkg::PWM_HALF_END : fmic_pkg::PWM_NOM_END));
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      mcnt_q <= 9'h000;
      mcmp_q <= 9'h000;
      MOTOR_PWM_OUT <= 1'b0;
      LOAD_CTRL_ON_OUT <= 1'b0;
    end else begin
      mcnt_q <= mend ? 9'h000 : mcnt_q + 9'h001;
      if (mend) begin
        mcmp_q <= fmic_scale(duty_w, pwm_half);
      end
      MOTOR_PWM_OUT <= (mcnt_q < mcmp_q);
      LOAD_CTRL_ON_OUT <= (load_inf != 8'h00);
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  property p_load_off;
    (load_inf == 8'h00) |-> (corr_w == 10'sd0) ##1 !LOAD_CTRL_ON_OUT;
  endproperty
  a_load_off: assert property (p_load_off) else $error("load control not off");
  property p_pwm_nom;
    (!pwm_half && mcnt_q == fmic_pkg::PWM_NOM_END) |=> (mcnt_q == 9'h000);
  endproperty
  a_pwm_nom: assert property (p_pwm_nom) else $error("nominal period wrong");
  property p_pwm_half;
    (pwm_half && mcnt_q == fmic_pkg::PWM_NOM_END) |=> (mcnt_q == 9'(fmic_pkg::PWM_NOM_CYC));
  endproperty
  a_pwm_half: assert property (p_pwm_half) else $error("half rate period wrong");
  property p_scale;
    (load_inf == 8'hFF && SPEED_IN == 8'h80 && EMF_IN == 8'h40) |-> (corr_w == 10'sd63);
  endproperty
  a_scale: assert property (p_scale) else $error("load scaling wrong");
  property p_bank;
    (CFG_RD_IN && addr_upper && !bank_ok) |=> (CFG_RDATA_OUT == 8'h00);
  endproperty
  a_bank: assert property (p_bank) else $error("unheld bank read nonzero");
  property p_fixed;
    (CFG_WR_IN && !addr_upper && CFG_ADDR_IN != 9'h000) ##1
      (CFG_RD_IN && CFG_ADDR_IN == $past(CFG_ADDR_IN)) |=> (CFG_RDATA_OUT == $past(CFG_WDATA_IN, 2));
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed range readback wrong");
  property p_disabled;
    1'b1 |=> ((LIGHT_OUT & ~$past(light_en)) == 6'h00);
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled output lit");
  property p_auxiliary_output_four;
    (bank_q[2][10][5] && bank_q[2][26][5] && bank_q[2][42][5] && bank_q[2][58][5])
      |-> out_mask[fmic_pkg::AUX_FOUR_BIT];
  endproperty
  a_auxiliary_output_four: assert property (p_auxiliary_output_four) else $error("aux four not held on");
endmodule : fmic_top
`default_nettype wire

// File: fmic_station.sv
`timescale 1ns/100ps
`default_nettype none
// command station model: owns the programming port, the keys and the travel state
module fmic_station (
  // clock
  input wire logic clk_in,
  // programming port
  output logic [8:0] cfg_addr_out,
  output logic [7:0] cfg_wdata_out,
  output logic cfg_wr_out,
  output logic cfg_rd_out,
  input wire logic [7:0] cfg_rdata_in,
  // travel state
  output logic [5:0] keys_out,
  output logic dir_rev_out,
  output logic moving_out,
  output logic [7:0] speed_out,
  output logic [7:0] emf_out
);
  // idle values at time zero
  initial begin
    cfg_addr_out = 9'h000;
    cfg_wdata_out = 8'h00;
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    keys_out = 6'h00;
    dir_rev_out = 1'b0;
    moving_out = 1'b0;
    speed_out = 8'h00;
    emf_out = 8'h00;
  end

  // one write cycle; released data flips so a stale value is never mistaken for live
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_in);
    cfg_addr_out <= a;
    cfg_wdata_out <= d;
    cfg_wr_out <= 1'b1;
    @(posedge clk_in);
    cfg_wr_out <= 1'b0;
    cfg_wdata_out <= ~d;
  endtask : wr

  // one read cycle; data taken in the following cycle only
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk_in);
    cfg_addr_out <= a;
    cfg_rd_out <= 1'b1;
    @(posedge clk_in);
    cfg_rd_out <= 1'b0;
    cfg_addr_out <= ~a;
    @(negedge clk_in);
    d = cfg_rdata_in;
  endtask : rd

  // write then read of one number with no idle cycle, so readback sees the new value
  task automatic wr_rd(input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_in);
    cfg_addr_out <= a;
    cfg_wdata_out <= d;
    cfg_wr_out <= 1'b1;
    @(posedge clk_in);
    cfg_wr_out <= 1'b0;
    cfg_rd_out <= 1'b1;
    @(posedge clk_in);
    cfg_rd_out <= 1'b0;
    @(negedge clk_in);
    q = cfg_rdata_in;
  endtask : wr_rd

  // lighting key is bit zero, the other keys count upward from one
  task automatic key(input int k, input logic on);
    @(posedge clk_in);
    keys_out[k] <= on;
  endtask : key

  // direction, moving flag, throttle and measured back voltage
  task automatic travel(input logic rev, input logic mov, input logic [7:0] spd,
                        input logic [7:0] emf);
    @(posedge clk_in);
    dir_rev_out <= rev;
    moving_out <= mov;
    speed_out <= spd;
    emf_out <= emf;
  endtask : travel
endmodule : fmic_station
`default_nettype wire

// File: fmic_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module fmic_tb_top;
  logic sys_clk;
  logic resetn;
  logic [8:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic cfg_wr;
  logic cfg_rd;
  logic [7:0] cfg_rdata;
  logic [5:0] keys;
  logic dir_rev;
  logic moving;
  logic [7:0] speed;
  logic [7:0] emf;
  logic motor_pwm;
  logic load_on;
  logic [5:0] lights;
  int fails;
  int compares;
  int c0;
  int c1;
  int c2;
  logic [7:0] rnd [4];

  // short effect tick keeps ramps within a few hundred cycles
  fmic_top #(.TICK_CYCLES(8)) fmic_top_i (
    .SYS_CLK_IN(sys_clk), .RESETN_IN(resetn), .CFG_ADDR_IN(cfg_addr),
    .CFG_WDATA_IN(cfg_wdata), .CFG_WR_IN(cfg_wr), .CFG_RD_IN(cfg_rd),
    .CFG_RDATA_OUT(cfg_rdata), .FUNC_KEYS_IN(keys), .DIR_REVERSE_IN(dir_rev),
    .MOVING_IN(moving), .SPEED_IN(speed), .EMF_IN(emf), .MOTOR_PWM_OUT(motor_pwm),
    .LOAD_CTRL_ON_OUT(load_on), .LIGHT_OUT(lights));

  fmic_station fmic_station_i (
    .clk_in(sys_clk), .cfg_addr_out(cfg_addr), .cfg_wdata_out(cfg_wdata),
    .cfg_wr_out(cfg_wr), .cfg_rd_out(cfg_rd), .cfg_rdata_in(cfg_rdata),
    .keys_out(keys), .dir_rev_out(dir_rev), .moving_out(moving),
    .speed_out(speed), .emf_out(emf));

  // 100 ns clock
  always #50 sys_clk = ~sys_clk;

  task automatic end_of_test;
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t byte %h want %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_cnt(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      fails++;
      $display("BAD %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_cnt

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] v;
    fmic_station_i.rd(a, v);
    chk_byte(v, exp);
  endtask : rd_chk

  // high cycles of one output over two light pwm periods, after a short settle
  task automatic lit(input int o, output int c);
    c = 0;
    repeat (4) @(negedge sys_clk);
    repeat (64) begin
      @(negedge sys_clk);
      if (lights[o] === 1'b1) c++;
    end
  endtask : lit

  // cycles with head and rear lit together, after the same settle as lit
  task automatic both(output int c);
    c = 0;
    repeat (4) @(negedge sys_clk);
    repeat (64) begin
      @(negedge sys_clk);
      if (lights[0] === 1'b1 && lights[1] === 1'b1) c++;
    end
  endtask : both

  // motor high time and period from one rising edge to the next, bounded
  task automatic motor(output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    while (motor_pwm === 1'b1 && n < 1200) begin @(negedge sys_clk); n++; end
    while (motor_pwm !== 1'b1 && n < 1200) begin @(negedge sys_clk); n++; end
    while (motor_pwm === 1'b1 && n < 1200) begin @(negedge sys_clk); n++; hi++; end
    per = hi;
    while (motor_pwm !== 1'b1 && n < 1200) begin @(negedge sys_clk); n++; per++; end
    if (n >= 1200) begin
      fails++;
      $display("BAD %0t motor pwm edge timeout", $time);
      end_of_test();
    end
  endtask : motor

  // start 3 plus throttle 128 plus scaled error of 64 steps, spread over the period
  function automatic int exp_duty(input int infl);
    return ((3 + 128 + ((64 * infl) >>> 8)) * fmic_pkg::PWM_NOM_CYC) >>> 8;
  endfunction : exp_duty

  function automatic int exp_period(input logic half);
    return half ? 2 * fmic_pkg::PWM_NOM_CYC : fmic_pkg::PWM_NOM_CYC;
  endfunction : exp_period

  // main sequence
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    fails = 0;
    compares = 0;
    void'($urandom(32'h2391BB12));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    // values after reset; address zero reads nothing
    rd_chk(9'h002, 8'h03);
    rd_chk(9'h01F, 8'h10);
    rd_chk(9'h020, 8'h00);
    rd_chk(9'h031, 8'h02);
    rd_chk(9'h038, 8'hFF);
    rd_chk(9'h000, 8'h00);
    // one upper number holds a different random byte in each bank
    for (int b = 0; b < 4; b++) begin
      rnd[b] = 8'($urandom());
      fmic_station_i.wr(9'h020, 8'(b));
      fmic_station_i.wr(9'h10D, rnd[b]);
    end
    for (int b = 0; b < 4; b++) begin
      fmic_station_i.wr(9'h020, 8'(b));
      rd_chk(9'h10D, rnd[b]);
    end
    fmic_station_i.wr(9'h01F, 8'h11);
    fmic_station_i.wr(9'h10D, 8'h5A);
    rd_chk(9'h10D, 8'h00);
    fmic_station_i.wr(9'h01F, 8'h10);
    rd_chk(9'h10D, rnd[3]);
    fmic_station_i.wr(9'h064, rnd[0]);
    fmic_station_i.wr(9'h020, 8'h01);
    rd_chk(9'h064, rnd[0]);
    fmic_station_i.wr_rd(9'h065, rnd[1], rnd[2]);
    chk_byte(rnd[2], rnd[1]);
    // influence 0, half and full with the loco running slower than asked
    fmic_station_i.travel(1'b0, 1'b1, 8'h80, 8'h40);
    for (int i = 0; i < 3; i++) begin
      c1 = (i == 0) ? 0 : (i == 1) ? 128 : 255;
      fmic_station_i.wr(9'h038, 8'(c1));
      motor(c0, c2);
      motor(c0, c2);
      chk_cnt(c0, exp_duty(c1) - 1, exp_duty(c1) + 1);
      chk_byte({7'h00, load_on}, {7'h00, c1 != 0});
      chk_cnt(c2, exp_period(1'b0), exp_period(1'b0));
    end
    fmic_station_i.wr(9'h031, 8'h00);
    motor(c0, c2);
    motor(c0, c2);
    chk_cnt(c2, exp_period(1'b1), exp_period(1'b1));
    // key one maps to head and rear, key two to head; outputs not yet enabled
    fmic_station_i.wr(9'h020, 8'h02);
    fmic_station_i.wr(9'h16A, 8'h03);
    fmic_station_i.wr(9'h18A, 8'h01);
    fmic_station_i.travel(1'b0, 1'b1, 8'h00, 8'h00);
    fmic_station_i.key(1, 1'b1);
    lit(0, c0);
    chk_cnt(c0, 0, 0);
    fmic_station_i.wr(9'h020, 8'h00);
    for (int o = 0; o < 2; o++) begin
      fmic_station_i.wr(9'(259 + 8 * o), 8'h01);
      fmic_station_i.wr(9'(262 + 8 * o), 8'h1F);
    end
    // every key pair in both directions; reverse rows are empty
    for (int k = 0; k < 8; k++) begin
      fmic_station_i.key(1, k[0]);
      fmic_station_i.key(2, k[1]);
      fmic_station_i.travel(k[2], 1'b1, 8'h00, 8'h00);
      lit(0, c0);
      lit(1, c1);
      chk_cnt(c0, (!k[2] && k[1:0] != 0) ? 40 : 0, (!k[2] && k[1:0] != 0) ? 64 : 0);
      chk_cnt(c1, (!k[2] && k[0]) ? 40 : 0, (!k[2] && k[0]) ? 64 : 0);
    end
    // key three raises the dimmer flag; head is marked dimmable
    fmic_station_i.wr(9'h107, 8'h10);
    fmic_station_i.wr(9'h020, 8'h02);
    fmic_station_i.wr(9'h1AC, 8'h40);
    fmic_station_i.travel(1'b0, 1'b1, 8'h00, 8'h00);
    fmic_station_i.key(1, 1'b1);
    lit(0, c0);
    fmic_station_i.key(3, 1'b1);
    lit(0, c1);
    chk_cnt(c1 * 2, c0 - 8, c0 + 8);
    fmic_station_i.key(3, 1'b0);
    fmic_station_i.key(1, 1'b0);
    fmic_station_i.key(2, 1'b0);
    // let the head fade level run down before fade mode is tried
    repeat (300) @(posedge sys_clk);
    // fade head: early cycles stay darker than the settled level
    fmic_station_i.wr(9'h020, 8'h00);
    fmic_station_i.wr(9'h103, 8'h02);
    fmic_station_i.key(1, 1'b1);
    lit(0, c0);
    repeat (300) @(posedge sys_clk);
    lit(0, c1);
    chk_cnt(c0, 0, c1 / 2);
    // ditch lights without crossing flag: type one steady, type two dark
    for (int m = 0; m < 2; m++) begin
      fmic_station_i.wr(9'h103, 8'(9 + m));
      lit(0, c0);
      chk_cnt(c0, (m == 0) ? 40 : 0, (m == 0) ? 64 : 0);
    end
    // flasher at top rate on head and rear; phase select flips their relation
    for (int o = 0; o < 2; o++) begin
      fmic_station_i.wr(9'(259 + 8 * o), 8'h0C);
      fmic_station_i.wr(9'(260 + 8 * o), 8'hFE);
    end
    lit(0, c0);
    chk_cnt(c0, 20, 44);
    both(c0);
    fmic_station_i.wr(9'h10F, 8'h01);
    both(c1);
    chk_cnt((c0 < c1) ? c0 : c1, 0, 0);
    chk_cnt(c0 + c1, 20, 44);
    // random brightness on a steady head shows twice in two light pwm periods
    fmic_station_i.wr(9'h103, 8'h01);
    c2 = $urandom() % 32;
    fmic_station_i.wr(9'h106, 8'(c2));
    lit(0, c0);
    chk_cnt(c0, 2 * c2, 2 * c2);
    fmic_station_i.key(1, 1'b0);
    // value 32 in the four stand and travel rows keeps aux four on
    fmic_station_i.wr(9'h12B, 8'h01);
    fmic_station_i.wr(9'h12E, 8'h1F);
    fmic_station_i.wr(9'h020, 8'h02);
    for (int r = 0; r < 4; r++) fmic_station_i.wr(9'(266 + 16 * r), 8'h20);
    for (int s = 0; s < 4; s++) begin
      fmic_station_i.travel(s[0], s[1], 8'($urandom()), 8'h00);
      lit(5, c0);
      chk_cnt(c0, 40, 64);
    end
    end_of_test();
  end
endmodule : fmic_tb_top
`default_nettype wire
